/* verif/mgmt_host.sv */
// Purpose: Management host issuing single register accesses.
// Assumes: One access at a time, launched just after a rising edge.
// Notes:   Released address lines show inverted values.
`timescale 1ns/1ps
module mgmt_host (
   input  logic        clk,
   output logic        rd_strobe = 1'b0,
   output logic        wr_strobe = 1'b0,
   output logic [4:0]  dev_addr = 5'h00,
   output logic [15:0] reg_addr = 16'h0000,
   output logic [15:0] wr_data = 16'h0000
);
   task automatic access(input logic w, input logic [4:0] d, input logic [15:0] a);
      @(posedge clk);
      {rd_strobe, wr_strobe, dev_addr, reg_addr, wr_data} <= {!w, w, d, a, ~a};
      @(posedge clk);
      {rd_strobe, wr_strobe, dev_addr, reg_addr} <= {2'b00, ~d, ~a};
      #1;
   endtask
endmodule

/* verif/partner_base_page_regs_properties.sv */
// Purpose: Port checks for the partner base page registers.
// Assumes: Read data follows the taken strobe by one cycle.
// Notes:   Bound to the design after the module.
`timescale 1ns/1ps
module partner_base_page_regs_properties (
   input logic        clk, rstn, rd_strobe, rd_valid, rd_hit,
   input logic        partner_more_pages_request, partner_codeword_received,
   input logic        partner_fault_flag, partner_role_forced,
   input logic [1:0]  partner_flow_control,
   input logic [4:0]  dev_addr, partner_protocol_field,
   input logic [15:0] reg_addr, rd_data
);
   wire        sel = rd_strobe && dev_addr == 5'h07;
   wire        lo = sel && reg_addr == 16'h0205;
   wire        mid = sel && reg_addr == 16'h0206;
   wire [10:0] f = {partner_more_pages_request, partner_codeword_received, partner_fault_flag,
                    partner_role_forced, partner_flow_control, partner_protocol_field};
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_next_page: assert property (lo |=> rd_data[15] == $past(f[10])) else $error("bit 15");
   a_ack_bit: assert property (lo |=> rd_data[14] == $past(f[9])) else $error("bit 14");
   a_fault_bit: assert property (lo |=> rd_data[13] == $past(f[8])) else $error("bit 13");
   a_role_kind: assert property (lo |=> rd_data[12] == $past(f[7])) else $error("bit 12");
   a_pause_pair: assert property (lo |=> rd_data[11:10] == $past(f[6:5])) else $error("pause");
   a_select_field: assert property (lo |=> rd_data[4:0] == $past(f[4:0])) else $error("sel");
   a_mid_reserved: assert property (mid |=> (rd_data & 16'hBF0F) == 16'h0000) else $error("mid");
   a_no_stray: assert property (!sel |=> !rd_valid) else $error("stray valid");
   a_low_hit: assert property (lo |=> rd_valid && rd_hit && rd_data[9:5] == 5'h00) else $error("low");
endmodule
bind partner_base_page_regs partner_base_page_regs_properties i_chk (.*);

/* verif/test_partner_base_page_regs.sv */
// Purpose: Self-checking bench for the partner base page registers.
// Assumes: Reads answer one cycle after the strobe.
// Notes:   Rows hold live low and middle words with expected reads.
`timescale 1ns/1ps
module test_partner_base_page_regs;
   logic        clk = 1'b0, rstn = 1'b0, rd_valid, rd_hit, rd_strobe, wr_strobe;
   logic [4:0]  dev_addr;
   logic [15:0] lo = 16'h0000, mi = 16'h0000, rd_data, reg_addr, wr_data;
   int          err_total = 0, check_count = 0;
   logic [15:0] rows [3][4] = '{'{16'hFFFF, 16'hFFFF, 16'hFC1F, 16'h40F0},
      '{16'hA801, 16'h4050, 16'hA801, 16'h4050}, '{16'h5401, 16'h00A0, 16'h5401, 16'h00A0}};
   partner_base_page_regs i_partner_base_page_regs (.*, .partner_more_pages_request(lo[15]),
      .partner_codeword_received(lo[14]), .partner_fault_flag(lo[13]),
      .partner_role_forced(lo[12]), .partner_flow_control(lo[11:10]),
      .partner_protocol_field(lo[4:0]), .partner_long_reach_ability(mi[14]),
      .partner_gigabit_t1_ability(mi[7]), .partner_short_reach_full_duplex(mi[6]),
      .partner_fast_t1_ability(mi[5]), .partner_master_role(mi[4]), .partner_base_page_high(mi));
   mgmt_host i_mgmt_host (.*);
   initial forever #2.5 clk = ~clk;
   task chk(input string n, input logic [15:0] e, g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #2000;
      err_total++;
      report_and_stop;
   end
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clk);
         {lo, mi} <= {rows[i][0], rows[i][1]};
         i_mgmt_host.access(1'b0, 5'h07, 16'h0205);
         chk("low", rows[i][2], rd_data);
         chk("flags", 16'h0003, {14'h0, rd_valid, rd_hit});
         @(posedge clk);
         {lo, mi} <= ~{rows[i][0], rows[i][1]};
         i_mgmt_host.access(1'b0, 5'h07, 16'h0206);
         chk("mid", rows[i][3], rd_data);
         i_mgmt_host.access(1'b0, 5'h07, 16'h0207);
         chk("high", rows[i][1] & 16'h7800, rd_data);
      end
      $display("rows done");
      i_mgmt_host.access(1'b1, 5'h07, 16'h0205);
      chk("write", 16'h0000, {15'h0, rd_valid});
      i_mgmt_host.access(1'b0, 5'h07, 16'h0204);
      chk("unmapped", 16'h0000, rd_data | {15'h0, rd_hit});
      i_mgmt_host.access(1'b0, 5'h01, 16'h0205);
      chk("other dev", 16'h0000, {15'h0, rd_valid});
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("reset outputs", 16'h0000, rd_data | {14'h0, rd_valid, rd_hit});
      @(posedge clk);
      rstn <= 1'b1;
      i_mgmt_host.access(1'b0, 5'h07, 16'h0206);
      chk("mid after reset", 16'h0000, rd_data);
      $display("edge cases done");
      report_and_stop;
   end
endmodule

/* verilog/page_snapshot.v */
// Purpose: Holding copies of the middle and high partner words.
// Assumes: capture is a one-cycle pulse in the clk domain.
// Notes:   Copies are masked so reserved bits stay zero.
`timescale 1ns/1ps
`include "partner_page_regs.vh"
module page_snapshot (
   input  wire        clk,
   input  wire        rstn,
   input  wire        capture,
   input  wire [15:0] live_mid,
   input  wire [15:0] live_high,
   output reg  [15:0] held_mid,
   output reg  [15:0] held_high
);
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         held_mid  <= `RESET_VALUE;
         held_high <= `RESET_VALUE;
      end else if (capture) begin
         held_mid  <= live_mid & `MID_MASK;
         held_high <= live_high & `HIGH_MASK;
      end
   end
endmodule

/* verilog/partner_base_page_regs.v */
// Purpose: Read-only registers reporting the partner's advertised base page.
// Assumes: The management front end gives a one-cycle read strobe with device and
//          register address; live page bits come from the autonegotiation core.
// Notes:   Read data is registered and valid one cycle after the strobe.
`timescale 1ns/1ps
`include "partner_page_regs.vh"
// Summary of operation
// - A read of the low word copies the live middle and high words into holding registers.
// - A read of the middle word returns the copy from the last low-word read since reset, or zero if there has been none.
// - Low bit 15 reports that the partner wants to send another next page.
// - Low bit 14 reports the partner's acknowledge of our codeword.
// - Low bit 13 reports the partner's remote fault.
// - Low bit 12 reads 0 for a preferred role and 1 for a forced role.
// - Low bits 11 to 10 carry the partner's pause abilities.
// - Low bits 4 to 0 carry the partner's selector field.
// - Middle bit 14 reports long-reach 10 Mb/s ability.
// - Middle bit 7 reports gigabit single-pair ability.
// - Middle bit 6 reports short-reach 10 Mb/s full-duplex ability.
// - Middle bit 5 reports 100 Mb/s single-pair ability.
// - Middle bit 4 reports the partner's role, 1 for master.
module partner_base_page_regs (
   input  wire        clk,
   input  wire        rstn,
   input  wire        rd_strobe,
   input  wire        wr_strobe,
   input  wire [4:0]  dev_addr,
   input  wire [15:0] reg_addr,
   input  wire [15:0] wr_data,
   input  wire        partner_more_pages_request,
   input  wire        partner_codeword_received,
   input  wire        partner_fault_flag,
   input  wire        partner_role_forced,
   input  wire [1:0]  partner_flow_control,
   input  wire [4:0]  partner_protocol_field,
   input  wire        partner_long_reach_ability,
   input  wire        partner_gigabit_t1_ability,
   input  wire        partner_short_reach_full_duplex,
   input  wire        partner_fast_t1_ability,
   input  wire        partner_master_role,
   input  wire [15:0] partner_base_page_high,
   output reg  [15:0] rd_data,
   output reg         rd_valid,
   output reg         rd_hit
);
   reg  [15:0] live_low;
   reg  [15:0] live_mid;
   reg  [15:0] next_rd_data;
   wire        dev_sel;
   wire        low_read;
   wire [15:0] held_mid;
   wire [15:0] held_high;

   always @* begin
      live_low = 16'h0000;
      live_low[`LOW_MORE_PAGES_BIT]  = partner_more_pages_request;
      live_low[`LOW_CODEWORD_RX_BIT] = partner_codeword_received;
      live_low[`LOW_FAULT_BIT]       = partner_fault_flag;
      live_low[`LOW_ROLE_FORCED_BIT] = partner_role_forced;
      live_low[`LOW_FLOW_HI:`LOW_FLOW_LO] = partner_flow_control;
      live_low[`LOW_PROTOCOL_HI:`LOW_PROTOCOL_LO] = partner_protocol_field;
   end

   always @* begin
      live_mid = 16'h0000;
      live_mid[`MID_LONG_REACH_BIT] = partner_long_reach_ability;
      live_mid[`MID_GIGABIT_BIT]    = partner_gigabit_t1_ability;
      live_mid[`MID_SHORT_FD_BIT]   = partner_short_reach_full_duplex;
      live_mid[`MID_FAST_BIT]       = partner_fast_t1_ability;
      live_mid[`MID_MASTER_BIT]     = partner_master_role;
   end

   assign dev_sel  = (dev_addr == `AN_DEV_ADDR);
   assign low_read = rd_strobe & dev_sel & (reg_addr == `REG_PARTNER_LOW);

   page_snapshot u_snapshot (
      .clk       (clk),
      .rstn      (rstn),
      .capture   (low_read),
      .live_mid  (live_mid),
      .live_high (partner_base_page_high),
      .held_mid  (held_mid),
      .held_high (held_high)
   );

   // Unmapped addresses read as zero; writes never reach any storage.
   always @* begin
      next_rd_data = 16'h0000;
      case (reg_addr)
         `REG_PARTNER_LOW:  next_rd_data = live_low & `LOW_MASK;
         `REG_PARTNER_MID:  next_rd_data = held_mid;
         `REG_PARTNER_HIGH: next_rd_data = held_high;
         default:           next_rd_data = 16'h0000;
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data  <= `RESET_VALUE;
         rd_valid <= 1'b0;
         rd_hit   <= 1'b0;
      end else begin
         rd_valid <= rd_strobe & dev_sel;
         if (rd_strobe & dev_sel) begin
            rd_data <= next_rd_data;
            rd_hit  <= (reg_addr == `REG_PARTNER_LOW) |
                       (reg_addr == `REG_PARTNER_MID) |
                       (reg_addr == `REG_PARTNER_HIGH);
         end
      end
   end
endmodule

/* verilog/partner_page_regs.vh */
// Purpose: Offsets, field positions and masks of the partner base page registers.
// Assumes: Registers are 16 bits wide, addressed within the autonegotiation device.
// Notes:   Included by its bare name.
`ifndef PARTNER_PAGE_REGS_VH
`define PARTNER_PAGE_REGS_VH
`define AN_DEV_ADDR            5'h07
`define REG_PARTNER_LOW        16'h0205
`define REG_PARTNER_MID        16'h0206
`define REG_PARTNER_HIGH       16'h0207
`define LOW_MORE_PAGES_BIT     15
`define LOW_CODEWORD_RX_BIT    14
`define LOW_FAULT_BIT          13
`define LOW_ROLE_FORCED_BIT    12
`define LOW_FLOW_HI            11
`define LOW_FLOW_LO            10
`define LOW_PROTOCOL_HI        4
`define LOW_PROTOCOL_LO        0
`define MID_LONG_REACH_BIT     14
`define MID_GIGABIT_BIT        7
`define MID_SHORT_FD_BIT       6
`define MID_FAST_BIT           5
`define MID_MASTER_BIT         4
`define LOW_MASK               16'hFC1F
`define MID_MASK               16'h40F0
`define HIGH_MASK              16'h7800
`define RESET_VALUE            16'h0000
`endif
